/* File: dv/ebtc_props.sv */
// Port checker for the timer pair
`timescale 1ns/1ps
module ebtc_props import ebtc_pkg::*; (
  input wire logic clk, input wire logic reset_n, input wire logic hsel,
  input wire logic [31:0] haddr, input wire logic [1:0] htrans, input wire logic hwrite,
  input wire logic [2:0] hsize, input wire logic [31:0] hwdata, input wire logic hready,
  input wire logic [31:0] hrdata, input wire logic hreadyout, input wire logic hresp,
  input wire logic sleep_mode, input wire logic [1:0] external_count_pin,
  input wire logic [1:0] sensing_oscillator_signal, input wire logic [1:0] overflow_pulse,
  input wire logic irq
);
  // ----------------------------------------------------------------
  // Shadow of on bits and mask, taken from bus writes
  // ----------------------------------------------------------------
  logic wr_reg, rd_reg;
  logic [7:0] a_reg;
  logic [1:0] on_reg, mask_reg;
  always_ff @(posedge clk) begin
    wr_reg <= reset_n && hsel && hready && htrans == HTRANS_NONSEQ && hwrite;
    rd_reg <= reset_n && hsel && hready && htrans == HTRANS_NONSEQ && !hwrite;
    a_reg <= haddr[7:0];
  end
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      on_reg <= 2'h0;
      mask_reg <= 2'h0;
    end else if (wr_reg) begin
      if (a_reg == TIMER_A_CONTROL_OFF) on_reg[0] <= hwdata[TIMER_ON_BIT];
      if (a_reg == TIMER_B_CONTROL_OFF) on_reg[1] <= hwdata[TIMER_ON_BIT];
      if (a_reg == IRQ_MASK_OFF) mask_reg <= hwdata[1:0];
    end
  end
  // ----------------------------------------------------------------
  // Properties
  // ----------------------------------------------------------------
  default clocking @(posedge clk); endclocking
  default disable iff (!reset_n);
  a_bus_okay: assert property (hreadyout && !hresp) else $error("bus answer not okay");
  a_pulse_single: assert property (overflow_pulse[0] |=> !overflow_pulse[0])
    else $error("overflow pulse too long");
  a_sleep_freeze: assert property (sleep_mode [*3] |-> overflow_pulse == 2'h0)
    else $error("overflow during sleep");
  a_off_quiet: assert property (!on_reg[0] [*3] |-> !overflow_pulse[0])
    else $error("overflow while off");
  a_ctrl_gap: assert property (rd_reg && a_reg[7:3] == 5'h0 |-> !hrdata[6])
    else $error("control bit six set");
  a_upper_zero: assert property (rd_reg |-> hrdata[31:8] == '0) else $error("upper bits set");
  // Edge of a tick in the cycle before the write may still overflow the old value
  a_write_hold: assert property (wr_reg && a_reg == TIMER_A_COUNT_OFF |-> ##1 !overflow_pulse[0] [*6])
    else $error("count moved after write");
  a_irq_follow: assert property (overflow_pulse[0] && mask_reg[0] |-> irq)
    else $error("irq missing");
  a_mask_quiet: assert property (mask_reg == 2'h0 |-> !irq) else $error("masked irq");
  a_pulse_single_b: assert property (overflow_pulse[1] |=> !overflow_pulse[1])
    else $error("overflow pulse b too long");
  c_overflow: cover property (overflow_pulse[0] && irq);
  c_sleep: cover property (sleep_mode && on_reg[0]);
  c_read: cover property (rd_reg && a_reg == IRQ_STATUS_OFF);
endmodule
bind ebtc_timer_pair ebtc_props i_props (.clk(clk), .reset_n(reset_n), .hsel(hsel),
  .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
  .hready(hready), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
  .sleep_mode(sleep_mode), .external_count_pin(external_count_pin),
  .sensing_oscillator_signal(sensing_oscillator_signal), .overflow_pulse(overflow_pulse),
  .irq(irq));

/* File: dv/ebtc_source_model.sv */
// Model of the external count pins and sensing oscillators
`timescale 1ns/1ps
module ebtc_source_model (
  input wire logic clk,
  input wire logic [3:0] run,
  output logic [1:0] external_count_pin,
  output logic [1:0] sensing_oscillator_signal
);
  // Four clocks per half period, so Q2/Q4 sampling sees every level
  logic [3:0] lvl = 4'h0;
  assign external_count_pin = lvl[1:0];
  assign sensing_oscillator_signal = lvl[3:2];
  for (genvar i = 0; i < 4; i++) begin : g_line
    logic [1:0] ph = 2'h0;
    always @(posedge clk) begin
      ph <= run[i] ? ph + 2'h1 : 2'h0;
      if (run[i] && ph == 2'h3) lvl[i] <= ~lvl[i];
    end
  end
endmodule

/* File: dv/tb.sv */
// Self-checking bench for the timer pair
`timescale 1ns/1ps
module tb;
  import ebtc_pkg::*;
  logic clk = 0, reset_n = 0, hsel = 0, hwrite = 0, sleep_mode = 0, rd_ph = 0;
  logic [31:0] haddr = 0, hwdata = 0, rnd = 32'h0000_d2a0;
  logic [1:0] htrans = 0;
  logic [3:0] run = 0;
  logic [63:0] q[$];
  logic [63:0] e;
  wire logic [31:0] hrdata;
  wire logic hreadyout, hresp, irq;
  wire logic [1:0] pin, osc, ovf;
  int n_fail = 0, num_checks = 0;
  always #4 clk = ~clk;
  ebtc_timer_pair i_dut (.clk(clk), .reset_n(reset_n), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout),
    .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .sleep_mode(sleep_mode),
    .external_count_pin(pin), .sensing_oscillator_signal(osc), .overflow_pulse(ovf), .irq(irq));
  ebtc_source_model i_src (.clk(clk), .run(run), .external_count_pin(pin),
    .sensing_oscillator_signal(osc));
  function automatic logic [31:0] xs(input logic [31:0] s);
    s ^= s << 13;
    s ^= s >> 17;
    s ^= s << 5;
    return s;
  endfunction
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    hsel <= 1;
    htrans <= HTRANS_NONSEQ;
    hwrite <= w;
    haddr <= {24'h00_0000, a};
    do @(posedge clk); while (hreadyout !== 1'b1);
    hsel <= 0;
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge clk); while (hreadyout !== 1'b1);
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] lo, input logic [7:0] hi);
    q.push_back({24'h00_0000, lo, 24'h00_0000, hi});
    bus(0, a, 0);
  endtask
  // Settle time covers the write inhibit and the input synchroniser
  task automatic drive(input logic [3:0] m, input int n);
    repeat (12) @(posedge clk);
    run <= m;
    repeat (n) @(posedge clk);
    run <= 0;
    repeat (12) @(posedge clk);
  endtask
  task automatic chk(input logic v, input logic x);
    num_checks++;
    if (v !== x) begin
      n_fail++;
      $display("ERROR irq expected %0b seen %0b", x, v);
    end
  endtask
  task automatic stop_test;
    $display("checks %0d mismatches %0d", num_checks, n_fail);
    if (n_fail == 0 && num_checks > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask
  // ----------------------------------------------------------------
  // Read data checker
  // ----------------------------------------------------------------
  always @(posedge clk) begin
    if (rd_ph) begin
      e = q.pop_front();
      num_checks++;
      if ($isunknown(hrdata) || hrdata < e[63:32] || hrdata > e[31:0]) begin
        n_fail++;
        $display("ERROR hrdata expected %0h..%0h seen %0h", e[63:32], e[31:0], hrdata);
      end
    end
    rd_ph <= hsel && htrans == HTRANS_NONSEQ && !hwrite;
  end
  initial begin
    repeat (40000) @(posedge clk);
    n_fail++;
    $display("ERROR watchdog expected done seen hang");
    stop_test;
  end
  // ----------------------------------------------------------------
  // Tests
  // ----------------------------------------------------------------
  initial begin
    repeat (12) @(posedge clk);
    reset_n <= 1;
    for (int i = 0; i < 8; i++) rd(8'(i * 4), 0, 0);
    bus(1, TIMER_B_CONTROL_OFF, 32'h0000_007f);
    rd(TIMER_B_CONTROL_OFF, 8'h3f, 8'h3f);
    bus(1, TIMER_B_CONTROL_OFF, 0);
    bus(1, 8'h1c, 32'hffff_ffff);
    rd(8'h1c, 0, 0);
    repeat (4) begin
      rnd = xs(rnd);
      bus(1, TIMER_A_COUNT_OFF, {24'h00_0000, rnd[7:0]});
      rd(TIMER_A_COUNT_OFF, rnd[7:0], rnd[7:0]);
    end
    $display("test registers done");
    bus(1, TIMER_A_CONTROL_OFF, 32'h0000_0088);
    bus(1, TIMER_A_COUNT_OFF, 0);
    repeat (96) @(posedge clk);
    rd(TIMER_A_COUNT_OFF, 21, 23);
    bus(1, TIMER_B_CONTROL_OFF, 32'h0000_0080);
    bus(1, TIMER_B_COUNT_OFF, 0);
    repeat (96) @(posedge clk);
    rd(TIMER_B_COUNT_OFF, 10, 12);
    bus(1, TIMER_B_CONTROL_OFF, 0);
    $display("test internal done");
    bus(1, TIMER_A_CONTROL_OFF, 32'h0000_00a8);
    bus(1, TIMER_A_COUNT_OFF, 0);
    drive(4'h1, 36);
    rd(TIMER_A_COUNT_OFF, 5, 5);
    bus(1, TIMER_A_CONTROL_OFF, 32'h0000_00b8);
    bus(1, TIMER_A_COUNT_OFF, 0);
    drive(4'h1, 28);
    rd(TIMER_A_COUNT_OFF, 4, 4);
    bus(1, SENSING_CONTROL_OFF, 32'h0000_0002);
    bus(1, TIMER_B_CONTROL_OFF, 32'h0000_00a8);
    bus(1, TIMER_B_COUNT_OFF, 0);
    drive(4'h2, 24);
    drive(4'h8, 16);
    rd(TIMER_B_COUNT_OFF, 2, 2);
    sleep_mode <= 1;
    drive(4'h1, 16);
    rd(TIMER_A_COUNT_OFF, 4, 4);
    sleep_mode <= 0;
    bus(1, TIMER_A_CONTROL_OFF, 32'h0000_0038);
    drive(4'h1, 16);
    rd(TIMER_A_COUNT_OFF, 4, 4);
    $display("test external done");
    for (int c = 0; c < 8; c++) begin
      bus(1, TIMER_A_CONTROL_OFF, 32'h0000_00a0 | c);
      bus(1, TIMER_A_COUNT_OFF, 0);
      drive(4'h1, 24 << c);
      rd(TIMER_A_COUNT_OFF, 1, 1);
    end
    $display("test prescaler done");
    bus(1, IRQ_MASK_OFF, 1);
    bus(1, TIMER_A_CONTROL_OFF, 32'h0000_00a8);
    bus(1, TIMER_A_COUNT_OFF, 32'h0000_00fe);
    drive(4'h1, 16);
    @(negedge clk) chk(irq, 1);
    rd(IRQ_STATUS_OFF, 1, 1);
    bus(1, IRQ_STATUS_OFF, 1);
    rd(IRQ_STATUS_OFF, 0, 0);
    @(negedge clk) chk(irq, 0);
    bus(1, IRQ_MASK_OFF, 0);
    bus(1, TIMER_A_COUNT_OFF, 32'h0000_00ff);
    drive(4'h1, 8);
    @(negedge clk) chk(irq, 0);
    rd(IRQ_STATUS_OFF, 1, 1);
    $display("test interrupt done");
    repeat (4) @(posedge clk);
    stop_test;
  end
endmodule

/* File: include/ebtc_pkg.sv */
// Package for the eight-bit timer/counter pair: register map, fields, timing
package ebtc_pkg;
  // ----------------------------------------------------------------
  // Register byte offsets
  // ----------------------------------------------------------------
  localparam logic [7:0] TIMER_A_CONTROL_OFF = 8'h00;
  localparam logic [7:0] TIMER_B_CONTROL_OFF = 8'h04;
  localparam logic [7:0] TIMER_A_COUNT_OFF = 8'h08;
  localparam logic [7:0] TIMER_B_COUNT_OFF = 8'h0C;
  localparam logic [7:0] SENSING_CONTROL_OFF = 8'h10;
  localparam logic [7:0] IRQ_STATUS_OFF = 8'h14;
  localparam logic [7:0] IRQ_MASK_OFF = 8'h18;
  // ----------------------------------------------------------------
  // Control register fields
  // ----------------------------------------------------------------
  localparam int TIMER_ON_BIT = 7;
  localparam int CLOCK_SOURCE_SELECT = 5;
  localparam int SOURCE_EDGE_SELECT = 4;
  localparam int PRESCALER_BYPASS = 3;
  localparam int PRESCALE_RATE_MSB = 2;
  localparam logic [7:0] CONTROL_WRITE_MASK = 8'hBF;
  localparam int EXTERNAL_SOURCE_PICK_A = 0;
  localparam int EXTERNAL_SOURCE_PICK_B = 1;
  // ----------------------------------------------------------------
  // Reset values and timing
  // ----------------------------------------------------------------
  localparam logic [7:0] CONTROL_RESET = 8'h00;
  localparam logic [7:0] COUNT_RESET = 8'h00;
  localparam logic [7:0] COUNT_MAX = 8'hFF;
  localparam int PHASES_PER_CYCLE = 4;
  localparam logic [1:0] PHASE_Q2 = 2'd1;
  localparam logic [1:0] PHASE_Q4 = 2'd3;
  localparam logic [1:0] WRITE_INHIBIT_CYCLES = 2'd2;
  localparam logic [1:0] HTRANS_NONSEQ = 2'b10;
endpackage

/* File: logic/ebtc_timer_pair.sv */
// Two eight-bit timer/counters with prescalers behind an AHB-Lite slave
//
// Our own choices: the AHB-Lite interface to the registers and the placing of the registers.
`timescale 1ns/1ps
// Functional notes
// - External counts are sampled from the prescaler output only in the second and fourth phase; with bit 3 set the code counts external edges in any phase.
// - A timer counts only while bit 7 of its control register is one.
// - A disabled timer keeps its count.
// - Turning a timer on clears its prescaler.
// - During sleep both timers stop and keep their counts.
// - Bit 5 picks external edges when one, else the system clock divided by four.
// - Bit 4 picks falling external edges when one, rising when zero.
// - Bit 3 bypasses the prescaler when one, else the prescaler output clocks the timer.
// - Bits 2 to 0 choose a prescale of two to the power code plus one.
// - Bit 6 of a control register ignores writes and reads zero.
// - Each overflow from FFh to 00h sets the flag, cleared only by a software write.
// - A count write blocks incrementing for the two instruction cycles that follow.
// - A count write clears the prescaler when in use; the prescaler is not accessible.
// - A pick bit in the sensing control register selects oscillator when one, pin when zero.
module ebtc_timer_pair (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  input wire logic sleep_mode,
  input wire logic [1:0] external_count_pin,
  input wire logic [1:0] sensing_oscillator_signal,
  output logic [1:0] overflow_pulse,
  output logic irq
);
  import ebtc_pkg::*;

  // ----------------------------------------------------------------
  // Bus slave
  // ----------------------------------------------------------------
  logic wr_pend_reg;
  logic [7:0] wr_addr_reg;
  logic [7:0] control_reg [2];
  logic [7:0] count_reg [2];
  logic [1:0] sensing_control_reg;
  logic [1:0] status_reg;
  logic [1:0] mask_reg;
  logic [1:0] phase_reg;
  logic [1:0] ovf_set;
  logic [1:0] cnt_wr;

  function automatic logic [7:0] timer_offset(input int unsigned t, input logic cnt);
    if (cnt) begin
      timer_offset = (t == 0) ? TIMER_A_COUNT_OFF : TIMER_B_COUNT_OFF;
    end else begin
      timer_offset = (t == 0) ? TIMER_A_CONTROL_OFF : TIMER_B_CONTROL_OFF;
    end
  endfunction

  wire addr_ok = hsel && hready && htrans == HTRANS_NONSEQ;
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      wr_pend_reg <= 1'b0;
      wr_addr_reg <= 8'h00;
    end else if (hready) begin
      wr_pend_reg <= addr_ok && hwrite;
      wr_addr_reg <= haddr[7:0];
    end
  end

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      hrdata <= 32'h0000_0000;
    end else if (addr_ok && !hwrite) begin
      case (haddr[7:0])
        TIMER_A_CONTROL_OFF: hrdata <= {24'h00_0000, control_reg[0]};
        TIMER_B_CONTROL_OFF: hrdata <= {24'h00_0000, control_reg[1]};
        TIMER_A_COUNT_OFF: hrdata <= {24'h00_0000, count_reg[0]};
        TIMER_B_COUNT_OFF: hrdata <= {24'h00_0000, count_reg[1]};
        SENSING_CONTROL_OFF: hrdata <= {30'h0000_0000, sensing_control_reg};
        IRQ_STATUS_OFF: hrdata <= {30'h0000_0000, status_reg};
        IRQ_MASK_OFF: hrdata <= {30'h0000_0000, mask_reg};
        default: hrdata <= 32'h0000_0000;
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      sensing_control_reg <= 2'b00;
      mask_reg <= 2'b00;
    end else if (wr_pend_reg) begin
      if (wr_addr_reg == SENSING_CONTROL_OFF) begin
        sensing_control_reg <= hwdata[1:0];
      end
      if (wr_addr_reg == IRQ_MASK_OFF) begin
        mask_reg <= hwdata[1:0];
      end
    end
  end

  // ----------------------------------------------------------------
  // Interrupts
  // ----------------------------------------------------------------
  // Set beats a simultaneous write-one clear
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      status_reg <= 2'b00;
    end else begin
      status_reg <= (status_reg & ~((wr_pend_reg && wr_addr_reg == IRQ_STATUS_OFF)
                    ? hwdata[1:0] : 2'b00)) | ovf_set;
    end
  end

  assign irq = |(status_reg & mask_reg);

  // ----------------------------------------------------------------
  // Instruction phase divider
  // ----------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      phase_reg <= 2'd0;
    end else begin
      phase_reg <= phase_reg + 2'd1;
    end
  end

  wire cycle_tick = phase_reg == PHASE_Q4;
  wire sample_tick = phase_reg == PHASE_Q2 || phase_reg == PHASE_Q4;

  // ----------------------------------------------------------------
  // Timers
  // ----------------------------------------------------------------
  genvar t;
  generate
    for (t = 0; t < 2; t++) begin : g_timer
      logic [1:0] sync_reg;
      logic src_last_reg;
      logic [7:0] prescale_reg;
      logic [7:0] prescale_next;
      logic pre_out_last_reg;
      logic [1:0] inhibit_reg;
      logic pulse_reg;
      logic raw_src;
      logic src_edge;
      logic pre_tick;
      logic pre_out;
      logic timer_tick;
      logic ctl_wr;
      logic turn_on;

      assign ctl_wr = wr_pend_reg && wr_addr_reg == timer_offset(t, 1'b0);
      assign cnt_wr[t] = wr_pend_reg && wr_addr_reg == timer_offset(t, 1'b1);
      assign turn_on = ctl_wr && hwdata[TIMER_ON_BIT] && !control_reg[t][TIMER_ON_BIT];

      // Raw pin passes two flops first
      assign raw_src = sensing_control_reg[t] ? sensing_oscillator_signal[t]
                                              : external_count_pin[t];
      always_ff @(posedge clk) begin
        if (!reset_n) begin
          sync_reg <= 2'b00;
          src_last_reg <= 1'b0;
        end else begin
          sync_reg <= {sync_reg[0], raw_src};
          src_last_reg <= sync_reg[1];
        end
      end

      assign src_edge = control_reg[t][SOURCE_EDGE_SELECT]
                        ? (src_last_reg && !sync_reg[1])
                        : (!src_last_reg && sync_reg[1]);
      assign pre_tick = control_reg[t][CLOCK_SOURCE_SELECT] ? src_edge : cycle_tick;

      always_comb begin
        prescale_next = prescale_reg;
        if (turn_on || (cnt_wr[t] && !control_reg[t][PRESCALER_BYPASS])) begin
          prescale_next = 8'h00;
        end else if (pre_tick && control_reg[t][TIMER_ON_BIT] && !sleep_mode) begin
          prescale_next = prescale_reg + 8'h01;
        end
      end

      always_ff @(posedge clk) begin
        if (!reset_n) begin
          prescale_reg <= 8'h00;
        end else begin
          prescale_reg <= prescale_next;
        end
      end

      // Prescaler output toggles at half the chosen ratio
      assign pre_out = control_reg[t][PRESCALER_BYPASS] ? (src_last_reg ^ sync_reg[1])
                       : prescale_reg[control_reg[t][PRESCALE_RATE_MSB:0]];

      // Sampling only at Q2/Q4 limits external rates to half the cycle
      always_ff @(posedge clk) begin
        if (!reset_n) begin
          pre_out_last_reg <= 1'b0;
        end else if (turn_on || cnt_wr[t]) begin
          // Stale high sample would fake a falling edge once cleared
          pre_out_last_reg <= 1'b0;
        end else if (sample_tick) begin
          pre_out_last_reg <= pre_out;
        end
      end

      always_comb begin
        timer_tick = 1'b0;
        if (control_reg[t][PRESCALER_BYPASS]) begin
          timer_tick = control_reg[t][CLOCK_SOURCE_SELECT] ? src_edge : cycle_tick;
        end else if (control_reg[t][CLOCK_SOURCE_SELECT]) begin
          timer_tick = sample_tick && pre_out_last_reg && !pre_out;
        end else begin
          timer_tick = cycle_tick && prescale_reg[control_reg[t][PRESCALE_RATE_MSB:0]]
                       && (prescale_next[control_reg[t][PRESCALE_RATE_MSB:0]] == 1'b0);
        end
      end

      always_ff @(posedge clk) begin
        if (!reset_n) begin
          control_reg[t] <= CONTROL_RESET;
        end else if (ctl_wr) begin
          control_reg[t] <= hwdata[7:0] & CONTROL_WRITE_MASK;
        end
      end

      always_ff @(posedge clk) begin
        if (!reset_n) begin
          inhibit_reg <= 2'd0;
        end else if (cnt_wr[t]) begin
          inhibit_reg <= WRITE_INHIBIT_CYCLES;
        end else if (cycle_tick && inhibit_reg != 2'd0) begin
          inhibit_reg <= inhibit_reg - 2'd1;
        end
      end

      wire do_inc = timer_tick && control_reg[t][TIMER_ON_BIT]
                    && !sleep_mode && inhibit_reg == 2'd0;
      assign ovf_set[t] = do_inc && count_reg[t] == COUNT_MAX && !cnt_wr[t];

      always_ff @(posedge clk) begin
        if (!reset_n) begin
          count_reg[t] <= COUNT_RESET;
        end else if (cnt_wr[t]) begin
          count_reg[t] <= hwdata[7:0];
        end else if (do_inc) begin
          count_reg[t] <= count_reg[t] + 8'h01;
        end
      end

      always_ff @(posedge clk) begin
        if (!reset_n) begin
          pulse_reg <= 1'b0;
        end else begin
          pulse_reg <= ovf_set[t];
        end
      end
      assign overflow_pulse[t] = pulse_reg;
    end
  endgenerate
endmodule
